// ==== src/eeprom_front_defines.vh ====
// shared constants of the two-wire eeprom bus front end
`ifndef EEPROM_FRONT_DEFINES_VH
`define EEPROM_FRONT_DEFINES_VH

// core clock rate in MHz
`define CORE_CLK_MHZ                     100
// self-timed write duration in ms, longest time
`define SELF_TIMED_WRITE_DURATION_MS     5
// write duration in core cycles, an exact product with no rounding
`define SELF_TIMED_WRITE_CYCLES          (`SELF_TIMED_WRITE_DURATION_MS * 1000 * `CORE_CLK_MHZ)
// width of the write timer
`define WRITE_TIMER_W                    20
// bits in one bus word
`define WORD_BITS                        8
// last bit index before the acknowledge slot
`define LAST_BIT_IDX                     4'h7
// bit count once a whole word is in
`define WORD_DONE_CNT                    4'h8
// receive fifo depth and pointer width
`define RX_FIFO_DEPTH                    8
`define RX_FIFO_AW                       3
// byte sent when the user side has nothing ready
`define TX_IDLE_BYTE                     8'hff

`endif

// ==== src/eeprom_front.v ====
// two-wire eeprom bus front end with its receive fifo
`timescale 1ns/1ps
`include "eeprom_front_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// fifo with a registered output stage
module word_fifo #(
   parameter WIDTH = `WORD_BITS,
   parameter DEPTH = `RX_FIFO_DEPTH,
   parameter AW    = `RX_FIFO_AW
) (
   input  wire             core_clk,
   input  wire             rst,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output reg  [WIDTH-1:0] out_data_reg,
   output reg              out_valid_reg,
   input  wire             out_ready
);
   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [AW-1:0]    wr_ptr_reg;
   reg  [AW-1:0]    rd_ptr_reg;
   reg  [AW:0]      count_reg;
   wire             push;
   wire             pop;
   localparam [AW:0] FULL_CNT = DEPTH[AW:0];

   // full is honest: ready drops once every entry holds a word
   assign in_ready = (count_reg != FULL_CNT);
   assign push     = in_valid && in_ready;
   assign pop      = (count_reg != {(AW+1){1'b0}}) && (!out_valid_reg || out_ready);

   // storage, pointers and output stage
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wr_ptr_reg    <= {AW{1'b0}};
         rd_ptr_reg    <= {AW{1'b0}};
         count_reg     <= {(AW+1){1'b0}};
         out_valid_reg <= 1'b0;
         out_data_reg  <= {WIDTH{1'b0}};
      end else begin
         if (push) begin
            mem[wr_ptr_reg] <= in_data;
            wr_ptr_reg      <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            out_data_reg  <= mem[rd_ptr_reg];
            out_valid_reg <= 1'b1;
            rd_ptr_reg    <= rd_ptr_reg + 1'b1;
         end else if (out_ready) begin
            out_valid_reg <= 1'b0;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
module eeprom_front #(
   parameter WRITE_CYCLES = `SELF_TIMED_WRITE_CYCLES,
   parameter TIMER_W      = `WRITE_TIMER_W
) (
   input  wire                  core_clk,
   input  wire                  rst,
   input  wire                  scl_in,
   input  wire                  sda_in,
   output reg                   sda_out_reg,
   output reg                   sda_oe_reg,
   output wire [`WORD_BITS-1:0] rx_data,
   output wire                  rx_valid,
   input  wire                  rx_ready,
   input  wire [`WORD_BITS-1:0] tx_data,
   input  wire                  tx_valid,
   output reg                   tx_ready_reg,
   output reg                   write_busy_reg,
   output reg                   standby_reg
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_RX   = 3'h1;
   localparam [2:0] ST_ACK  = 3'h2;
   localparam [2:0] ST_TX   = 3'h3;
   localparam [2:0] ST_MACK = 3'h4;
   localparam [2:0] ST_WAIT = 3'h5;
   // load value of the write timer, cut to the timer's width on purpose
   localparam integer       WR_LAST_I = WRITE_CYCLES - 1;
   localparam [TIMER_W-1:0] WR_LAST   = WR_LAST_I[TIMER_W-1:0];

   reg  [1:0]            scl_sync_reg;
   reg  [1:0]            sda_sync_reg;
   reg                   scl_d_reg;
   reg                   sda_d_reg;
   reg  [2:0]            state_reg;
   reg  [3:0]            bit_cnt_reg;
   reg  [`WORD_BITS-1:0] shift_reg;
   reg                   first_word_reg;
   reg                   read_reg;
   reg                   got_data_reg;
   reg                   mack_seen_reg;
   reg  [TIMER_W-1:0]    timer_reg;
   wire                  scl_s;
   wire                  sda_s;
   wire                  start_det;
   wire                  stop_det;
   wire                  scl_rise;
   wire                  scl_fall;
   wire                  word_in;
   wire                  push;
   wire                  fifo_in_ready;
   wire [`WORD_BITS-1:0] tx_byte;

   ////////////////////////////////////////////////////////////////////////////
   // two-flop synchronisers; only stage two feeds the edge logic
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         scl_d_reg    <= 1'b1;
         sda_d_reg    <= 1'b1;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], scl_in};
         sda_sync_reg <= {sda_sync_reg[0], sda_in};
         scl_d_reg    <= scl_s;
         sda_d_reg    <= sda_s;
      end
   end

   assign scl_s = scl_sync_reg[1];
   assign sda_s = sda_sync_reg[1];

   // bus conditions: an sda edge while scl stays high is never data
   assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
   assign stop_det  = scl_s && scl_d_reg && !sda_d_reg && sda_s;
   assign scl_rise  = scl_s && !scl_d_reg;
   assign scl_fall  = !scl_s && scl_d_reg;

   // a whole word sits in the shifter at the fall after its eighth bit
   assign word_in = scl_fall && (state_reg == ST_RX) && (bit_cnt_reg == `WORD_DONE_CNT);
   // data words go to the fifo; a full fifo refuses the word with no ack
   assign push    = word_in && !first_word_reg && !read_reg && fifo_in_ready;
   // stale bytes are avoided by sending ones when the user has none
   assign tx_byte = tx_valid ? tx_data : `TX_IDLE_BYTE;

   ////////////////////////////////////////////////////////////////////////////
   // bit level engine; relies on the master holding sda while scl high
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg      <= ST_IDLE;
         bit_cnt_reg    <= 4'h0;
         shift_reg      <= 8'h00;
         first_word_reg <= 1'b1;
         read_reg       <= 1'b0;
         got_data_reg   <= 1'b0;
         mack_seen_reg  <= 1'b0;
         sda_oe_reg     <= 1'b0;
         sda_out_reg    <= 1'b0;
         tx_ready_reg   <= 1'b0;
      end else begin
         sda_out_reg  <= 1'b0;
         tx_ready_reg <= 1'b0;
         if (start_det) begin
            // any start, even mid-word, restarts with an address word
            state_reg      <= ST_RX;
            bit_cnt_reg    <= 4'h0;
            first_word_reg <= 1'b1;
            read_reg       <= 1'b0;
            got_data_reg   <= 1'b0;
            sda_oe_reg     <= 1'b0;
         end else if (stop_det) begin
            state_reg  <= ST_IDLE;
            sda_oe_reg <= 1'b0;
         end else begin
            case (state_reg)
               ST_RX: begin
                  if (scl_rise && bit_cnt_reg != `WORD_DONE_CNT) begin
                     shift_reg   <= {shift_reg[`WORD_BITS-2:0], sda_s};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (word_in) begin
                     if (first_word_reg) begin
                        read_reg <= shift_reg[0];
                        // polling during a write cycle gets no ack
                        sda_oe_reg <= !write_busy_reg;
                        state_reg  <= write_busy_reg ? ST_WAIT : ST_ACK;
                     end else if (read_reg || !fifo_in_ready) begin
                        state_reg <= ST_WAIT;
                     end else begin
                        got_data_reg <= 1'b1;
                        sda_oe_reg   <= 1'b1;
                        state_reg    <= ST_ACK;
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     first_word_reg <= 1'b0;
                     bit_cnt_reg    <= 4'h0;
                     if (read_reg) begin
                        // first bit goes out on the fall that ends the ack
                        shift_reg    <= tx_byte;
                        tx_ready_reg <= tx_valid;
                        sda_oe_reg   <= !tx_byte[`WORD_BITS-1];
                        state_reg    <= ST_TX;
                     end else begin
                        sda_oe_reg <= 1'b0;
                        state_reg  <= ST_RX;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     if (bit_cnt_reg == `LAST_BIT_IDX) begin
                        sda_oe_reg <= 1'b0;
                        state_reg  <= ST_MACK;
                     end else begin
                        shift_reg   <= {shift_reg[`WORD_BITS-2:0], 1'b1};
                        sda_oe_reg  <= !shift_reg[`WORD_BITS-2];
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     end
                  end
               end
               ST_MACK: begin
                  if (scl_rise) begin
                     mack_seen_reg <= !sda_s;
                  end else if (scl_fall) begin
                     bit_cnt_reg <= 4'h0;
                     if (mack_seen_reg) begin
                        shift_reg    <= tx_byte;
                        tx_ready_reg <= tx_valid;
                        sda_oe_reg   <= !tx_byte[`WORD_BITS-1];
                        state_reg    <= ST_TX;
                     end else begin
                        // master ended the read; stay off the line until a start or a stop
                        state_reg <= ST_WAIT;
                     end
                  end
               end
               ST_WAIT: begin
                  sda_oe_reg <= 1'b0;
               end
               default: begin
                  sda_oe_reg <= 1'b0;
                  state_reg  <= ST_IDLE;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // self-timed write cycle and standby; timer covers the worst-case duration
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         write_busy_reg <= 1'b0;
         timer_reg      <= {TIMER_W{1'b0}};
         standby_reg    <= 1'b1;
      end else begin
         if (write_busy_reg) begin
            if (timer_reg == {TIMER_W{1'b0}}) begin
               write_busy_reg <= 1'b0;
               standby_reg    <= 1'b1;
            end else begin
               timer_reg <= timer_reg - 1'b1;
            end
         end else if (stop_det && got_data_reg && !read_reg) begin
            write_busy_reg <= 1'b1;
            timer_reg      <= WR_LAST;
            standby_reg    <= 1'b0;
         end else if (stop_det && read_reg) begin
            standby_reg <= 1'b1;
         end else if (start_det) begin
            standby_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // received data words; a full fifo makes the device refuse the word
   word_fifo #(
      .WIDTH (`WORD_BITS),
      .DEPTH (`RX_FIFO_DEPTH),
      .AW    (`RX_FIFO_AW)
   ) rx_fifo (
      .core_clk      (core_clk),
      .rst           (rst),
      .in_data       (shift_reg),
      .in_valid      (push),
      .in_ready      (fifo_in_ready),
      .out_data_reg  (rx_data),
      .out_valid_reg (rx_valid),
      .out_ready     (rx_ready)
   );
endmodule

// ==== dv/eeprom_front_props.sv ====
// port checker of the two-wire eeprom front end
`timescale 1ns/1ps
module eeprom_front_props #(
   parameter WRITE_CYCLES = 200,
   parameter TIMER_W      = 20
) (
   input wire core_clk,
   input wire rst,
   input wire scl_in,
   input wire sda_in,
   input wire sda_out_reg,
   input wire sda_oe_reg,
   input wire tx_valid,
   input wire tx_ready_reg,
   input wire write_busy_reg,
   input wire standby_reg
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   reg [TIMER_W-1:0] busy_cnt;
   // length of the running write cycle; too long for a repetition count
   always @(posedge core_clk or posedge rst) begin
      if (rst)
         busy_cnt <= {TIMER_W{1'h0}};
      else
         busy_cnt <= write_busy_reg ? busy_cnt + 1'h1 : {TIMER_W{1'h0}};
   end
   ////////////////////////////////////////////////////////////////////////////
   sequence bus_start; $fell(sda_in) && scl_in && !write_busy_reg; endsequence
   sequence bus_stop; $rose(sda_in) && scl_in; endsequence
   sequence ack_slot; sda_oe_reg [*5]; endsequence
   ////////////////////////////////////////////////////////////////////////////
   chk_drive_low: assert property (sda_out_reg == 1'h0)
      else $error("sda drive value not low");
   chk_oe_scl_low: assert property ($changed(sda_oe_reg) |-> !$past(scl_in, 2))
      else $error("sda drive moved while scl high");
   chk_ack_stands: assert property ($rose(sda_oe_reg) |-> ack_slot)
      else $error("sda pull released too soon");
   chk_no_ack_busy: assert property ($rose(sda_oe_reg) |-> !write_busy_reg)
      else $error("sda pulled during write cycle");
   chk_busy_bound: assert property (write_busy_reg |-> busy_cnt <= WRITE_CYCLES + 1)
      else $error("write cycle too long");
   chk_busy_length: assert property ($fell(write_busy_reg) |-> busy_cnt >= WRITE_CYCLES)
      else $error("write cycle too short");
   chk_standby_done: assert property ($fell(write_busy_reg) |-> ##[0:1] standby_reg)
      else $error("no standby after write cycle");
   chk_start_wake: assert property (bus_start |-> ##[1:6] !standby_reg)
      else $error("start did not leave standby");
   chk_stop_quiet: assert property (bus_stop |-> ##1 (!sda_oe_reg) [*8])
      else $error("sda pulled after stop");
   chk_tx_take: assert property (tx_ready_reg |-> $past(tx_valid) ##1 !tx_ready_reg)
      else $error("bad transmit take pulse");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind eeprom_front eeprom_front_props #(.WRITE_CYCLES(WRITE_CYCLES), .TIMER_W(TIMER_W))
   props (.*);

// ==== dv/bus_master_model.sv ====
// two-wire bus master model driving the front end's bus pins
`timescale 1ns/1ps
module bus_master_model (
   input  wire  core_clk,
   input  wire  sda_wire,
   output logic scl,
   output logic sda_drv
);
   logic b;
   // both lines idle high through the pull-up
   initial begin
      scl = 1'h1;
      sda_drv = 1'h1;
   end
   ////////////////////////////////////////////////////////////////////////////
   // set both pins just after an edge, then hold them n core cycles
   task step(input logic c, input logic d, input int n);
      scl <= c;
      sda_drv <= d;
      repeat (n) @(posedge core_clk);
   endtask
   // one bit: sda moves mid low phase, wire sampled mid high phase
   task bit_slot(input logic d, output logic s);
      step(1'h0, sda_drv, 2);
      step(1'h0, d, 2);
      step(1'h1, d, 2);
      s = sda_wire;
      step(1'h1, d, 2);
   endtask
   // eight bits msb first, then the acknowledge slot
   task xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_slot(d[i], b);
         q[i] = b;
      end
      bit_slot(ack_in, ack);
   endtask
   // long low wait first so a device acknowledge is gone before sda rises
   task start_cond;
      step(1'h0, sda_drv, 4);
      step(1'h0, 1'h1, 2);
      step(1'h1, 1'h1, 3);
      step(1'h1, 1'h0, 3);
   endtask
   // scl then stands high until the next frame
   task stop_cond;
      step(1'h0, sda_drv, 4);
      step(1'h0, 1'h0, 2);
      step(1'h1, 1'h0, 3);
      step(1'h1, 1'h1, 4);
   endtask
   task recover;
      start_cond();
      repeat (9) bit_slot(1'h1, b);
      start_cond();
      stop_cond();
   endtask
endmodule

// ==== dv/test_serial_eeprom_bus_front_end.sv ====
// self-checking bench of the two-wire eeprom front end
`timescale 1ns/1ps
module test_serial_eeprom_bus_front_end;
   localparam int WC = 200;
   logic       core_clk = 1'h0;
   logic       rst      = 1'h1;
   logic       rx_ready = 1'h0;
   logic       tx_valid = 1'h0;
   logic [7:0] tx_data  = 8'h00;
   logic [7:0] q;
   logic       a;
   wire        scl, sda_drv, sda_oe_reg, rx_valid, write_busy_reg, standby_reg;
   wire        tx_ready_reg;
   wire [7:0]  rx_data;
   // open drain with pull-up: low while either party pulls
   wire        sda_wire = sda_drv & ~sda_oe_reg;
   int         err_total = 0;
   int         checked   = 0;
   int         cyc       = 0;
   int         tx_taken  = 0;
   always #5 core_clk = ~core_clk;
   eeprom_front #(.WRITE_CYCLES(WC)) uut (
      .core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda_wire), .sda_out_reg(),
      .sda_oe_reg(sda_oe_reg), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready_reg(tx_ready_reg),
      .write_busy_reg(write_busy_reg), .standby_reg(standby_reg));
   bus_master_model bus (.core_clk(core_clk), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));
   ////////////////////////////////////////////////////////////////////////////
   task tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task finish_test;
      if (err_total == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // take pulses counted so every byte loaded from tx_data is accounted for; idle byte loads give no pulse
   always @(posedge core_clk) begin
      if (tx_ready_reg === 1'h1)
         tx_taken <= tx_taken + 1;
   end
   // a hang counts as a mismatch
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         finish_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task t_reset;
      check(sda_oe_reg, 1'h0);
      check(standby_reg, 1'h1);
      check(write_busy_reg, 1'h0);
      check(rx_valid, 1'h0);
   endtask
   // user side stalled: nine words fit, the tenth is refused
   task t_write_fill;
      int n;
      bus.start_cond();
      bus.xfer(8'ha0, 1'h1, q, a);
      check(a, 1'h0);
      for (int i = 0; i < 10; i++) begin
         bus.xfer(8'h10 + i[7:0], 1'h1, q, a);
         check(a, i > 8);
      end
      bus.stop_cond();
      tick(8);
      check(write_busy_reg, 1'h1);
      check(standby_reg, 1'h0);
      bus.start_cond();
      bus.xfer(8'ha0, 1'h1, q, a);
      check(a, 1'h1);
      bus.stop_cond();
      for (int i = 0; i < 9; i++) begin
         n = 0;
         while (rx_valid !== 1'h1 && n < 20) begin
            tick(1);
            n++;
         end
         check(rx_data, 8'h10 + i[7:0]);
         rx_ready <= 1'h1;
         tick(1);
         rx_ready <= 1'h0;
         tick(1);
      end
      check(rx_valid, 1'h0);
      n = 0;
      while (write_busy_reg === 1'h1 && n < WC + 20) begin
         tick(1);
         n++;
      end
      check(write_busy_reg, 1'h0);
      tick(2);
      check(standby_reg, 1'h1);
   endtask
   // three bytes read: two acked by the master, then the idle byte refused
   task t_read;
      tx_data <= 8'h3c;
      tx_valid <= 1'h1;
      bus.start_cond();
      bus.xfer(8'ha1, 1'h1, q, a);
      check(a, 1'h0);
      bus.xfer(8'hff, 1'h0, q, a);
      check(q, 8'h3c);
      tx_data <= 8'h5a;
      bus.xfer(8'hff, 1'h0, q, a);
      check(q, 8'h5a);
      tx_valid <= 1'h0;
      bus.xfer(8'hff, 1'h1, q, a);
      check(q, 8'hff);
      check(tx_taken, 32'h2);
      bus.stop_cond();
      tick(8);
      check(standby_reg, 1'h1);
      check(sda_oe_reg, 1'h0);
   endtask
   // half a word abandoned by the recovery, then a fresh address
   task t_recover;
      bus.start_cond();
      repeat (4) bus.bit_slot(1'h0, a);
      bus.recover();
      bus.start_cond();
      bus.xfer(8'ha1, 1'h1, q, a);
      check(a, 1'h0);
      bus.stop_cond();
      tick(8);
      check(standby_reg, 1'h1);
      check(tx_taken, 32'h2);
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      rst <= 1'h0;
      tick(4);
      t_reset();
      t_write_fill();
      t_read();
      t_recover();
      finish_test();
   end
endmodule
